/* File: common/pcd_pkg.sv */
// constants for the port c/d override block
// assumes a 32-bit avalon-mm slave and a 100 mhz i/o clock
`default_nettype none
package pcd_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_PB_OUT = 5'h00;
    localparam logic [4:0] OFS_PB_DIR = 5'h04;
    localparam logic [4:0] OFS_PB_PIN = 5'h08;
    localparam logic [4:0] OFS_PC_OUT = 5'h0C;
    localparam logic [4:0] OFS_CTRL   = 5'h10;
    // reset values
    localparam logic [7:0] RST_PB_OUT = 8'h00;
    localparam logic [7:0] RST_PB_DIR = 8'h00;
    localparam logic [6:0] RST_PC_OUT = 7'h00;
    localparam logic [6:0] RST_CTRL   = 7'h00;
    // control field positions
    localparam int CTRL_TWO_WIRE = 0;
    localparam int CTRL_PUD      = 1;
    localparam int CTRL_SYNC     = 2;
    localparam int CTRL_TX_EN    = 3;
    localparam int CTRL_RX_EN    = 4;
    localparam int CTRL_IRQ0_EN  = 5;
    localparam int CTRL_IRQ1_EN  = 6;
    localparam int CTRL_W        = 7;
    // pin positions
    localparam int PC_RESET = 6;
    localparam int PC_TW_CK = 5;
    localparam int PC_TW_DA = 4;
    localparam int PD_SER_CK = 4;
    localparam int PD_T1    = 5;
    localparam int PD_IRQ1  = 3;
    localparam int PD_IRQ0  = 2;
    localparam int PD_TX    = 1;
    localparam int PD_RX    = 0;
    // spike filter timing
    localparam int SPIKE_NS  = 50;
    localparam int CLK_MHZ   = 100;
    localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
    // bus answer states
    typedef enum logic {BUS_IDLE, BUS_ANSWER} pcd_bus_t;
endpackage
`default_nettype wire

/* File: rtl/pcd_port_override.sv */
// port b/c registers and port c/d pin override logic
// assumes peripheral signals on i_clk, pad inputs asynchronous
`default_nettype none
module pcd_port_override (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // fuse and neighbouring port registers
    input  wire logic        i_reset_pin_disable,
    input  wire logic [6:0]  i_pc_dir,
    input  wire logic [7:0]  i_pd_out,
    input  wire logic [7:0]  i_pd_dir,
    // peripheral drive
    input  wire logic        i_tw_clock_out,
    input  wire logic        i_tw_data_out,
    input  wire logic        i_serial_ext_clock_out,
    input  wire logic        i_tx_data,
    // pad inputs
    input  wire logic [7:0]  i_pb_pin,
    input  wire logic [6:0]  i_pc_pin,
    input  wire logic [7:0]  i_pd_pin,
    // port b pads
    output logic      [7:0]  o_pb_out,
    output logic      [7:0]  o_pb_oe,
    output logic      [7:0]  o_pb_pullup,
    // port c pads
    output logic      [6:0]  o_pc_out,
    output logic      [6:0]  o_pc_oe,
    output logic      [6:0]  o_pc_pullup,
    output logic      [6:0]  o_pc_ie,
    output logic      [1:0]  o_pc_slew_limit,
    // port d pads
    output logic      [7:0]  o_pd_out,
    output logic      [7:0]  o_pd_oe,
    output logic      [7:0]  o_pd_pullup,
    output logic      [7:0]  o_pd_ie,
    // peripheral inputs
    output logic             o_reset_in,
    output logic             o_tw_clock_in,
    output logic             o_tw_data_in,
    output logic             o_serial_ext_clock_in,
    output logic             o_timer0_count_in,
    output logic             o_timer1_count_in,
    output logic             o_ext_irq_zero_in,
    output logic             o_ext_irq_one_in,
    output logic             o_rx_data_in,
    output logic             o_c6_reads_zero
);

    // override merge
    function automatic logic [7:0] pcd_ovr(
        input logic [7:0] en,
        input logic [7:0] val,
        input logic [7:0] dflt
    );
        pcd_ovr = (en & val) | (~en & dflt);
    endfunction

    // pad and fuse synchronisers
    logic [23:0] sync_meta_r, sync_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_meta_r <= 24'h000000;
            sync_r      <= 24'h000000;
        end else begin
            sync_meta_r <= {i_reset_pin_disable, i_pd_pin, i_pc_pin, i_pb_pin};
            sync_r      <= sync_meta_r;
        end
    end

    logic [7:0] pb_s, pc_s, pd_s;
    logic       rst_dis_s;
    assign pb_s      = sync_r[7:0];
    assign pc_s      = {1'b0, sync_r[14:8]};
    assign pd_s      = sync_r[22:15];
    assign rst_dis_s = sync_r[23];

    // registers
    logic [7:0]        pb_out_r, pb_dir_r;
    logic [6:0]        pc_out_r, ctrl_r;
    pcd_pkg::pcd_bus_t bus_r;
    logic              wr_go, reset_fn;

    assign wr_go    = (bus_r == pcd_pkg::BUS_ANSWER) && i_avs_write && i_avs_byteenable[0];
    assign reset_fn = ~rst_dis_s;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pb_out_r <= pcd_pkg::RST_PB_OUT;
            pb_dir_r <= pcd_pkg::RST_PB_DIR;
            pc_out_r <= pcd_pkg::RST_PC_OUT;
            ctrl_r   <= pcd_pkg::RST_CTRL;
        end else if (wr_go) begin
            case (i_avs_address)
                pcd_pkg::OFS_PB_OUT: pb_out_r <= i_avs_writedata[7:0];
                pcd_pkg::OFS_PB_DIR: pb_dir_r <= i_avs_writedata[7:0];
                pcd_pkg::OFS_PC_OUT: pc_out_r <= i_avs_writedata[6:0];
                pcd_pkg::OFS_CTRL:   ctrl_r   <= i_avs_writedata[6:0];
                default: begin
                end
            endcase
        end
    end

    logic two_wire_enable, pullup_disable_global, sync_sel, tx_en, rx_en, irq0_en, irq1_en;
    assign two_wire_enable     = ctrl_r[pcd_pkg::CTRL_TWO_WIRE];
    assign pullup_disable_global      = ctrl_r[pcd_pkg::CTRL_PUD];
    assign sync_sel = ctrl_r[pcd_pkg::CTRL_SYNC];
    assign tx_en    = ctrl_r[pcd_pkg::CTRL_TX_EN];
    assign rx_en    = ctrl_r[pcd_pkg::CTRL_RX_EN];
    assign irq0_en  = ctrl_r[pcd_pkg::CTRL_IRQ0_EN];
    assign irq1_en  = ctrl_r[pcd_pkg::CTRL_IRQ1_EN];

    // read mux
    logic [7:0] rd_nxt, pc_rd;

    always_comb begin
        pc_rd = {1'b0, pc_out_r};
        if (reset_fn) begin
            pc_rd[pcd_pkg::PC_RESET] = 1'b0;
        end
        case (i_avs_address)
            pcd_pkg::OFS_PB_OUT: rd_nxt = pb_out_r;
            pcd_pkg::OFS_PB_DIR: rd_nxt = pb_dir_r;
            pcd_pkg::OFS_PB_PIN: rd_nxt = pb_s;
            pcd_pkg::OFS_PC_OUT: rd_nxt = pc_rd;
            pcd_pkg::OFS_CTRL:   rd_nxt = {1'b0, ctrl_r};
            default:             rd_nxt = 8'h00;
        endcase
    end

    // bus handshake: one wait cycle, then answer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_r             <= pcd_pkg::BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h00000000;
        end else begin
            case (bus_r)
                pcd_pkg::BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_r             <= pcd_pkg::BUS_ANSWER;
                        o_avs_waitrequest <= 1'b0;
                        if (i_avs_read) begin
                            o_avs_readdata <= {24'h000000, rd_nxt};
                        end
                    end
                end
                pcd_pkg::BUS_ANSWER: begin
                    bus_r             <= pcd_pkg::BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_r             <= pcd_pkg::BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // override tables for ports c and d
    logic [7:0] c_pu_oe, c_pu_ov, c_dd_oe, c_dd_ov;
    logic [7:0] c_pv_oe, c_pv_ov, c_ie_oe, c_ie_ov;
    logic [7:0] d_pu_oe, d_pu_ov, d_dd_oe, d_dd_ov;
    logic [7:0] d_pv_oe, d_pv_ov, d_ie_oe, d_ie_ov;

    always_comb begin
        // c3..c0 and d7..d5 keep all zeros
        c_pu_oe = 8'h00;
        c_pu_ov = 8'h00;
        c_dd_oe = 8'h00;
        c_dd_ov = 8'h00;
        c_pv_oe = 8'h00;
        c_pv_ov = 8'h00;
        c_ie_oe = 8'h00;
        c_ie_ov = 8'h00;
        d_pu_oe = 8'h00;
        d_pu_ov = 8'h00;
        d_dd_oe = 8'h00;
        d_dd_ov = 8'h00;
        d_pv_oe = 8'h00;
        d_pv_ov = 8'h00;
        d_ie_oe = 8'h00;
        d_ie_ov = 8'h00;
        // reset pin
        c_pu_oe[pcd_pkg::PC_RESET] = reset_fn;
        c_pu_ov[pcd_pkg::PC_RESET] = 1'b1;
        c_dd_oe[pcd_pkg::PC_RESET] = reset_fn;
        c_ie_oe[pcd_pkg::PC_RESET] = reset_fn;
        // two-wire clock and data, open drain
        c_pu_oe[pcd_pkg::PC_TW_CK] = two_wire_enable;
        c_pu_oe[pcd_pkg::PC_TW_DA] = two_wire_enable;
        c_pu_ov[pcd_pkg::PC_TW_CK] = pc_out_r[pcd_pkg::PC_TW_CK] & ~pullup_disable_global;
        c_pu_ov[pcd_pkg::PC_TW_DA] = pc_out_r[pcd_pkg::PC_TW_DA] & ~pullup_disable_global;
        c_dd_oe[pcd_pkg::PC_TW_CK] = two_wire_enable;
        c_dd_oe[pcd_pkg::PC_TW_DA] = two_wire_enable;
        c_dd_ov[pcd_pkg::PC_TW_CK] = i_tw_clock_out;
        c_dd_ov[pcd_pkg::PC_TW_DA] = i_tw_data_out;
        c_pv_oe[pcd_pkg::PC_TW_CK] = two_wire_enable;
        c_pv_oe[pcd_pkg::PC_TW_DA] = two_wire_enable;
        // serial clock
        d_pv_oe[pcd_pkg::PD_SER_CK] = sync_sel;
        d_pv_ov[pcd_pkg::PD_SER_CK] = i_serial_ext_clock_out;
        // external interrupts
        d_ie_oe[pcd_pkg::PD_IRQ0] = irq0_en;
        d_ie_oe[pcd_pkg::PD_IRQ1] = irq1_en;
        d_ie_ov[pcd_pkg::PD_IRQ0] = 1'b1;
        d_ie_ov[pcd_pkg::PD_IRQ1] = 1'b1;
        // transmit
        d_pu_oe[pcd_pkg::PD_TX] = tx_en;
        d_dd_oe[pcd_pkg::PD_TX] = tx_en;
        d_dd_ov[pcd_pkg::PD_TX] = 1'b1;
        d_pv_oe[pcd_pkg::PD_TX] = tx_en;
        d_pv_ov[pcd_pkg::PD_TX] = i_tx_data;
        // receive
        d_dd_oe[pcd_pkg::PD_RX] = rx_en;
        d_pu_oe[pcd_pkg::PD_RX] = rx_en;
        d_pu_ov[pcd_pkg::PD_RX] = i_pd_out[pcd_pkg::PD_RX] & ~pullup_disable_global;
    end

    // final pad controls
    logic [7:0] c_dir, c_pu, c_val, c_ie;
    logic [7:0] d_dir, d_pu, d_val, d_ie;
    logic [7:0] c_port, pud_v;

    assign pud_v  = {8{pullup_disable_global}};
    assign c_port = {1'b0, pc_out_r};
    assign c_dir  = pcd_ovr(c_dd_oe, c_dd_ov, {1'b0, i_pc_dir});
    assign c_pu   = pcd_ovr(c_pu_oe, c_pu_ov, c_port & ~c_dir & ~pud_v);
    assign c_val  = pcd_ovr(c_pv_oe, c_pv_ov, c_port);
    assign c_ie   = pcd_ovr(c_ie_oe, c_ie_ov, 8'hFF);
    assign d_dir  = pcd_ovr(d_dd_oe, d_dd_ov, i_pd_dir);
    assign d_pu   = pcd_ovr(d_pu_oe, d_pu_ov, i_pd_out & ~d_dir & ~pud_v);
    assign d_val  = pcd_ovr(d_pv_oe, d_pv_ov, i_pd_out);
    assign d_ie   = pcd_ovr(d_ie_oe, d_ie_ov, 8'hFF);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pb_out    <= 8'h00;
            o_pb_oe     <= 8'h00;
            o_pb_pullup <= 8'h00;
        end else begin
            o_pb_out    <= pb_out_r;
            o_pb_oe     <= pb_dir_r;
            o_pb_pullup <= pb_out_r & ~pb_dir_r & ~pud_v;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pc_out        <= 7'h00;
            o_pc_oe         <= 7'h00;
            o_pc_pullup     <= 7'h00;
            o_pc_ie         <= 7'h00;
            o_pc_slew_limit <= 2'h0;
        end else begin
            o_pc_out        <= c_val[6:0];
            o_pc_oe         <= c_dir[6:0];
            o_pc_pullup     <= c_pu[6:0];
            o_pc_ie         <= c_ie[6:0];
            o_pc_slew_limit <= {two_wire_enable, two_wire_enable};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pd_out    <= 8'h00;
            o_pd_oe     <= 8'h00;
            o_pd_pullup <= 8'h00;
            o_pd_ie     <= 8'h00;
        end else begin
            o_pd_out    <= d_val;
            o_pd_oe     <= d_dir;
            o_pd_pullup <= d_pu;
            o_pd_ie     <= d_ie;
        end
    end

    // digital inputs to peripherals
    logic [7:0] d_in;
    assign d_in = pd_s & d_ie;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reset_in            <= 1'b1;
            o_serial_ext_clock_in <= 1'b0;
            o_timer0_count_in     <= 1'b0;
            o_timer1_count_in     <= 1'b0;
            o_ext_irq_zero_in     <= 1'b0;
            o_ext_irq_one_in      <= 1'b0;
            o_rx_data_in          <= 1'b0;
            o_c6_reads_zero       <= 1'b0;
        end else begin
            o_reset_in            <= reset_fn ? pc_s[pcd_pkg::PC_RESET] : 1'b1;
            o_serial_ext_clock_in <= d_in[pcd_pkg::PD_SER_CK];
            o_timer0_count_in     <= d_in[pcd_pkg::PD_SER_CK];
            o_timer1_count_in     <= d_in[pcd_pkg::PD_T1];
            o_ext_irq_zero_in     <= d_in[pcd_pkg::PD_IRQ0];
            o_ext_irq_one_in      <= d_in[pcd_pkg::PD_IRQ1];
            o_rx_data_in          <= d_in[pcd_pkg::PD_RX];
            o_c6_reads_zero       <= reset_fn;
        end
    end

    // two-wire spike filters, index 1 clock, 0 data
    logic [1:0] tw_raw, tw_filt_r;
    logic [2:0] tw_cnt_r [2];
    assign tw_raw = {pc_s[pcd_pkg::PC_TW_CK], pc_s[pcd_pkg::PC_TW_DA]};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tw_cnt_r[0] <= 3'h0;
            tw_cnt_r[1] <= 3'h0;
            tw_filt_r   <= 2'h3;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (tw_raw[k] == tw_filt_r[k]) begin
                    tw_cnt_r[k] <= 3'h0;
                end else if (tw_cnt_r[k] == 3'(pcd_pkg::SPIKE_CYC - 1)) begin
                    tw_cnt_r[k]  <= 3'h0;
                    tw_filt_r[k] <= tw_raw[k];
                end else begin
                    tw_cnt_r[k] <= tw_cnt_r[k] + 3'h1;
                end
            end
        end
    end

    assign o_tw_clock_in = tw_filt_r[1];
    assign o_tw_data_in  = tw_filt_r[0];

endmodule // pcd_port_override
`default_nettype wire

/* File: testbench/pcd_checker.sv */
// port relations of the port c/d override block
// assumes binding to pcd_port_override, one clock, async active-low reset
`default_nettype none
module pcd_checker (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    // watched inputs
    input wire logic [6:0] i_pc_dir,
    input wire logic [7:0] i_pd_out,
    input wire logic [7:0] i_pd_dir,
    input wire logic       i_tw_clock_out,
    input wire logic       i_tx_data,
    input wire logic [7:0] i_pd_pin,
    // watched outputs
    input wire logic [6:0] o_pc_out,
    input wire logic [6:0] o_pc_oe,
    input wire logic [6:0] o_pc_pullup,
    input wire logic [6:0] o_pc_ie,
    input wire logic [1:0] o_pc_slew_limit,
    input wire logic [7:0] o_pd_out,
    input wire logic [7:0] o_pd_oe,
    input wire logic [7:0] o_pd_pullup,
    input wire logic [7:0] o_pd_ie,
    input wire logic       o_reset_in,
    input wire logic       o_serial_ext_clock_in,
    input wire logic       o_timer0_count_in,
    input wire logic       o_timer1_count_in,
    input wire logic       o_c6_reads_zero,
    input wire logic       o_ext_irq_zero_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] up_r;
    // cycles since reset release, saturating, keeps $past away from reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h7) begin
            up_r <= up_r + 3'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_c6_held; (up_r == 3'h7 && o_c6_reads_zero) [*3]; endsequence
    sequence s_c6_free; (up_r == 3'h7 && !o_c6_reads_zero) [*3]; endsequence
    property p_tw_out_zero; up_r == 3'h7 && o_pc_slew_limit[0] |-> o_pc_out[5:4] == 2'b00; endproperty
    a_tw_out_zero: assert property (p_tw_out_zero) else $error("c5/c4 not driven low");
    property p_tw_dir;
        up_r == 3'h7 && o_pc_slew_limit[0] |-> o_pc_oe[5] == $past(i_tw_clock_out);
    endproperty
    a_tw_dir: assert property (p_tw_dir) else $error("c5 enable not from clock drive");
    property p_slew_pair; o_pc_slew_limit[0] == o_pc_slew_limit[1]; endproperty
    a_slew_pair: assert property (p_slew_pair) else $error("slew bits differ");
    property p_c_low; up_r == 3'h7 |-> o_pc_oe[3:0] == $past(i_pc_dir[3:0]); endproperty
    a_c_low: assert property (p_c_low) else $error("c3..c0 enable overridden");
    property p_tx_force;
        up_r == 3'h7 && o_pd_oe[1] && !$past(i_pd_dir[1])
            |-> !o_pd_pullup[1] && o_pd_out[1] == $past(i_tx_data);
    endproperty
    a_tx_force: assert property (p_tx_force) else $error("d1 transmit drive wrong");
    property p_rx_pu; up_r == 3'h7 && o_pd_pullup[0] |-> $past(i_pd_out[0]); endproperty
    a_rx_pu: assert property (p_rx_pu) else $error("d0 pull-up without data bit");
    property p_c6_reset; s_c6_held |-> o_pc_pullup[6] && !o_pc_oe[6] && !o_pc_ie[6]; endproperty
    a_c6_reset: assert property (p_c6_reset) else $error("c6 reset overrides wrong");
    property p_fuse_free; s_c6_free |-> o_reset_in; endproperty
    a_fuse_free: assert property (p_fuse_free) else $error("reset input active on free c6");
    property p_t1_path; up_r == 3'h7 |-> o_timer1_count_in == $past(i_pd_pin[5], 3); endproperty
    a_t1_path: assert property (p_t1_path) else $error("timer1 input not d5");
    property p_xck_t0; up_r == 3'h7 |-> o_serial_ext_clock_in == o_timer0_count_in; endproperty
    a_xck_t0: assert property (p_xck_t0) else $error("d4 inputs differ");
    property p_irq_ie;
        up_r == 3'h7 |-> o_pd_ie[3:2] == 2'b11 && o_ext_irq_zero_in == $past(i_pd_pin[2], 3);
    endproperty
    a_irq_ie: assert property (p_irq_ie) else $error("d3/d2 input disabled");
endmodule // pcd_checker
`default_nettype wire

/* File: testbench/pcd_pad_model.sv */
// pad cell model: resolves a pin level from the block's pad controls
// assumes an outside source level on pins neither driven nor pulled up
`default_nettype none
module pcd_pad_model #(
    parameter int W = 8
) (
    // pad controls from the block
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_oe,
    input  wire logic [W-1:0] i_pullup,
    // outside level, changed every override sweep step so a stale value seldom matches
    input  wire logic [W-1:0] i_ext,
    // resolved pin level
    output logic      [W-1:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_pin = (i_oe & i_out) | (~i_oe & i_pullup) | (~i_oe & ~i_pullup & i_ext);
endmodule // pcd_pad_model
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for pcd_port_override
// assumes pcd_pkg, the pad model and the checker are compiled first
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [31:0] rq;
    logic        wq;
    logic        fuse = 1'b0, twc = 1'b0, twd = 1'b0, sck = 1'b0, txd = 1'b0;
    logic [6:0]  pcd = 7'h00, extc = 7'h00, ctrl = 7'h00, pco = 7'h00;
    logic [7:0]  pdo = 8'h00, pdd = 8'h00, extb = 8'h00, extd = 8'h00, pbo = 8'h00, pbd = 8'h00;
    logic [7:0]  pbp, pbq, pbe, pbu, pdp, pdq, pde, pdu, pdi;
    logic [6:0]  pcp, pcq, pce, pcu, pci;
    logic [1:0]  slew;
    logic        rsi, tci, tdi, xci, t0i, t1i, i0i, i1i, rxi, c6z;
    logic [15:0] lfsr = 16'hFC6A;
    logic [4:0]  offs [4] = '{pcd_pkg::OFS_PB_OUT, pcd_pkg::OFS_PB_DIR,
                              pcd_pkg::OFS_PC_OUT, pcd_pkg::OFS_CTRL};
    int          n_fail = 0;
    int          n_tests = 0;
    always #5 i_clk = ~i_clk;
    pcd_port_override pcd_port_override_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rq), .o_avs_waitrequest(wq),
        .i_reset_pin_disable(fuse), .i_pc_dir(pcd), .i_pd_out(pdo), .i_pd_dir(pdd),
        .i_tw_clock_out(twc), .i_tw_data_out(twd), .i_serial_ext_clock_out(sck),
        .i_tx_data(txd), .i_pb_pin(pbp), .i_pc_pin(pcp), .i_pd_pin(pdp),
        .o_pb_out(pbq), .o_pb_oe(pbe), .o_pb_pullup(pbu), .o_pc_out(pcq), .o_pc_oe(pce),
        .o_pc_pullup(pcu), .o_pc_ie(pci), .o_pc_slew_limit(slew), .o_pd_out(pdq),
        .o_pd_oe(pde), .o_pd_pullup(pdu), .o_pd_ie(pdi), .o_reset_in(rsi),
        .o_tw_clock_in(tci), .o_tw_data_in(tdi), .o_serial_ext_clock_in(xci),
        .o_timer0_count_in(t0i), .o_timer1_count_in(t1i), .o_ext_irq_zero_in(i0i),
        .o_ext_irq_one_in(i1i), .o_rx_data_in(rxi), .o_c6_reads_zero(c6z));
    pcd_pad_model #(.W(8)) pad_b (.i_out(pbq), .i_oe(pbe), .i_pullup(pbu), .i_ext(extb), .o_pin(pbp));
    pcd_pad_model #(.W(7)) pad_c (.i_out(pcq), .i_oe(pce), .i_pullup(pcu), .i_ext(extc), .o_pin(pcp));
    pcd_pad_model #(.W(8)) pad_d (.i_out(pdq), .i_oe(pde), .i_pullup(pdu), .i_ext(extd), .o_pin(pdp));
    function automatic logic [7:0] rnd();
        for (int i = 0; i < 8; i++) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        adr <= a;
        wd <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge i_clk);
        end while (wq !== 1'b0);
        q = rq[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic check_all();
        logic [7:0] eo, ee, ep, pin, q;
        logic [6:0] co, ce, cp, ci, cpin;
        logic       rf, pullup_disable_global;
        rf = !fuse;
        pullup_disable_global = ctrl[1];
        ep = pbo & ~pbd & ~{8{pullup_disable_global}};
        chk({pbq, pbe, pbu}, {pbo, pbd, ep});
        pin = (pbd & pbo) | (~pbd & ep) | (~pbd & ~ep & extb);
        bus(1'b0, pcd_pkg::OFS_PB_PIN, 8'h00, q);
        chk(q, pin);
        co = pco;
        ce = pcd;
        cp = pco & ~pcd & ~{7{pullup_disable_global}};
        ci = 7'h7F;
        if (ctrl[0]) begin
            co[5:4] = 2'b00;
            ce[5:4] = {twc, twd};
            cp[5:4] = pco[5:4] & ~{2{pullup_disable_global}};
        end
        if (rf) begin
            cp[6] = 1'b1;
            ce[6] = 1'b0;
            ci[6] = 1'b0;
        end
        chk({pcq[6] & !rf, pcq[5:0]}, {co[6] & !rf, co[5:0]});
        chk({pce, pcu, pci}, {ce, cp, ci});
        chk(slew, {2{ctrl[0]}});
        cpin = (ce & co) | (~ce & cp) | (~ce & ~cp & extc);
        chk({rsi, c6z}, {rf ? cpin[6] : 1'b1, rf});
        if (ctrl[0]) chk({tci, tdi}, cpin[5:4]);
        eo = pdo;
        ee = pdd;
        ep = pdo & ~pdd & ~{8{pullup_disable_global}};
        if (ctrl[2]) eo[4] = sck;
        if (ctrl[3]) begin
            ee[1] = 1'b1;
            eo[1] = txd;
            ep[1] = 1'b0;
        end
        if (ctrl[4]) begin
            ee[0] = 1'b0;
            ep[0] = pdo[0] & !pullup_disable_global;
        end
        chk({pdq, pde, pdu, pdi}, {eo, ee, ep, 8'hFF});
        pin = (ee & eo) | (~ee & ep) | (~ee & ~ep & extd);
        chk({xci, t0i, t1i, i1i, i0i, rxi}, {pin[4], pin[4], pin[5], pin[3:2], pin[0]});
        bus(1'b0, pcd_pkg::OFS_PC_OUT, 8'h00, q);
        chk(q, {1'b0, pco[6] & !rf, pco[5:0]});
        bus(1'b0, pcd_pkg::OFS_PB_DIR, 8'h00, q);
        chk(q, pbd);
        bus(1'b0, pcd_pkg::OFS_CTRL, 8'h00, q);
        chk(q, {1'b0, ctrl});
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        finish_test();
    end
    initial begin
        logic [7:0] q;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, offs[i], 8'h00, q);
            chk(q, 8'h00);
        end
        $display("reset values done");
        for (int k = 0; k < 24; k++) begin
            @(posedge i_clk);
            fuse <= rnd() > 8'h7F;
            {twc, twd, sck, txd} <= 4'(rnd());
            pcd <= 7'(rnd());
            pdo <= rnd() & 8'h3F;
            pdd <= rnd() & 8'h3F;
            extb <= rnd();
            extc <= 7'(rnd());
            extd <= rnd();
            ctrl = (k < 7) ? 7'h01 << k : 7'(rnd());
            pbo = rnd();
            pbd = rnd();
            pco = 7'(rnd());
            bus(1'b1, pcd_pkg::OFS_CTRL, {1'b0, ctrl}, q);
            bus(1'b1, pcd_pkg::OFS_PB_OUT, pbo, q);
            bus(1'b1, pcd_pkg::OFS_PB_DIR, pbd, q);
            bus(1'b1, pcd_pkg::OFS_PC_OUT, {1'b0, pco}, q);
            repeat (16) @(posedge i_clk);
            check_all();
        end
        $display("override sweep done");
        @(posedge i_clk);
        be <= 4'hE;
        bus(1'b1, pcd_pkg::OFS_PB_OUT, ~pbo, q);
        @(posedge i_clk);
        be <= 4'hF;
        bus(1'b1, 5'h14, 8'hA5, q);
        bus(1'b0, 5'h14, 8'h00, q);
        chk(q, 8'h00);
        bus(1'b0, pcd_pkg::OFS_PB_OUT, 8'h00, q);
        chk(q, pbo);
        $display("refused access done");
        @(posedge i_clk);
        twc <= 1'b0;
        ctrl = 7'h01;
        pco = 7'h30;
        bus(1'b1, pcd_pkg::OFS_CTRL, 8'h01, q);
        bus(1'b1, pcd_pkg::OFS_PC_OUT, 8'h30, q);
        repeat (16) @(posedge i_clk);
        chk(tci, 1'b1);
        twc <= 1'b1;
        repeat (2) @(posedge i_clk);
        twc <= 1'b0;
        repeat (16) @(posedge i_clk);
        chk(tci, 1'b1);
        twc <= 1'b1;
        repeat (16) @(posedge i_clk);
        chk(tci, 1'b0);
        check_all();
        $display("spike filter done");
        finish_test();
    end
endmodule // tb
bind pcd_port_override pcd_checker pcd_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_pc_dir(i_pc_dir), .i_pd_out(i_pd_out), .i_pd_dir(i_pd_dir),
    .i_tw_clock_out(i_tw_clock_out), .i_tx_data(i_tx_data), .i_pd_pin(i_pd_pin),
    .o_pc_out(o_pc_out), .o_pc_oe(o_pc_oe), .o_pc_pullup(o_pc_pullup), .o_pc_ie(o_pc_ie),
    .o_pc_slew_limit(o_pc_slew_limit), .o_pd_out(o_pd_out), .o_pd_oe(o_pd_oe),
    .o_pd_pullup(o_pd_pullup), .o_pd_ie(o_pd_ie), .o_reset_in(o_reset_in),
    .o_serial_ext_clock_in(o_serial_ext_clock_in), .o_timer0_count_in(o_timer0_count_in),
    .o_timer1_count_in(o_timer1_count_in), .o_c6_reads_zero(o_c6_reads_zero),
    .o_ext_irq_zero_in(o_ext_irq_zero_in));
`default_nettype wire
